// >>> verilog/uemr_defines.svh
// Constants of the endpoint mode responder: modes, field positions, offsets.
// Assumes inclusion by uemr_responder.sv only, not by uemr_pkg.sv.
`ifndef UEMR_DEFINES_SVH
`define UEMR_DEFINES_SVH

// Endpoint mode encodings
`define UEMR_MODE_DISABLE      4'h0
`define UEMR_MODE_NAK_INOUT    4'h1
`define UEMR_MODE_STATUS_OUT   4'h2
`define UEMR_MODE_STALL_INOUT  4'h3
`define UEMR_MODE_IGN_INOUT    4'h4
`define UEMR_MODE_RSV_5        4'h5
`define UEMR_MODE_STATUS_IN    4'h6
`define UEMR_MODE_RSV_7        4'h7
`define UEMR_MODE_NAK_OUT      4'h8
`define UEMR_MODE_ACK_OUT      4'h9
`define UEMR_MODE_NAKOUT_STIN  4'hA
`define UEMR_MODE_ACKOUT_NAKIN 4'hB
`define UEMR_MODE_NAK_IN       4'hC
`define UEMR_MODE_ACK_IN       4'hD
`define UEMR_MODE_NAKIN_STOUT  4'hE
`define UEMR_MODE_ACKIN_STOUT  4'hF

// Mode register fields
`define UEMR_MODE_STALL_BIT    7
`define UEMR_FLAG_SETUP_BIT    7
`define UEMR_FLAG_IN_BIT       6
`define UEMR_FLAG_OUT_BIT      5
`define UEMR_FLAG_ACK_BIT      4
// Count register fields
`define UEMR_CNT_TOG_BIT       7
`define UEMR_CNT_DVAL_BIT      6

// Register word offsets (byte addresses) and register reset value
`define UEMR_OFS_MODE0         8'h00
`define UEMR_OFS_CNT0          8'h04
`define UEMR_OFS_BUF_LO        8'h18
`define UEMR_OFS_BUF_HI        8'h1C
`define UEMR_REG_RST           8'h00

// Packet sizes
`define UEMR_CRC_BYTES         5'h02
`define UEMR_EP_SIZE           8

// AXI responses
`define UEMR_RESP_OKAY         2'h0
`define UEMR_RESP_SLVERR       2'h2

`endif

// >>> verilog/uemr_pkg.sv
// Types shared by the endpoint mode responder and its bench.
// Assumes nothing beyond the defines header.
package uemr_pkg;

	typedef enum logic [2:0] {
		UEMR_ST_IDLE = 3'h1,
		UEMR_ST_DATA = 3'h2,
		UEMR_ST_HACK = 3'h4
	} uemr_state_t;

	typedef enum logic [1:0] {
		UEMR_PID_OUT   = 2'h0,
		UEMR_PID_IN    = 2'h1,
		UEMR_PID_SETUP = 2'h2
	} uemr_pid_t;

	// ZLP and CHECK are internal; only NONE..DATA leave the block
	typedef enum logic [2:0] {
		UEMR_RSP_NONE  = 3'h0,
		UEMR_RSP_ACK   = 3'h1,
		UEMR_RSP_NAK   = 3'h2,
		UEMR_RSP_STALL = 3'h3,
		UEMR_RSP_DATA  = 3'h4,
		UEMR_RSP_CHECK = 3'h5,
		UEMR_RSP_ZLP   = 3'h6
	} uemr_rsp_t;

endpackage

// >>> verilog/uemr_responder.sv
// Endpoint mode responder of a low-speed USB protocol engine, AXI4-Lite registers.
// Assumes a packet layer on aclk that decodes tokens and data packets into strobes.
// Functional notes
// R1 - Bit 7 stall turns ACK into STALL
// R2 - Mode bits [3:0] select token answers
// R3 - Mode 0001 ACKs SETUP, NAKs IN/OUT
// R4 - Check ACKs only zero-length DATA1 OUT
// R5 - TX count sends count register bytes
// R6 - TX zero answers IN with empty packet
// R7 - Ignored tokens get no handshake
// R8 - Accepted valid SETUP forces mode 0001
// R9 - Status OUT ACK in 1111 gives 1110
// R10 - Reset to disabled, stays until written
// R11 - Control endpoint flags SETUP, IN, OUT
// R12 - Invalid transactions get no answer
// R13 - Interrupt on completion or bad CRC
// R14 - Valid packet: checks pass, size limit
// R15 - OUT endpoints ignore IN, and reverse
// R16 - IN/OUT flags set at transaction end
// R17 - SETUP flag set at data start
// R18 - ACK locks control registers until read
// R19 - Firmware reads mode first in handler
// R20 - Firmware keeps SETUP off other endpoints
// R21 - Valid SETUP stores, flags, NAKs, interrupts
// R22 - ACKed OUT in 1001 gives 1000
// R23 - ACKed IN in 1101 gives 1100
// R24 - ACKed OUT in 1011 gives 0001
// R25 - NAK-all: valid NAK, invalid silent
// R26 - Bad SETUP: silent, flag, interrupt
`include "uemr_defines.svh"

module uemr_responder #(
	parameter int NUM_EP  = 3,
	parameter int EP_SIZE = `UEMR_EP_SIZE
) (
	// Clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Token from the packet layer
	input  wire logic                tok_valid,
	input  wire uemr_pkg::uemr_pid_t tok_pid,
	input  wire logic [1:0]          tok_ep,
	input  wire logic                tok_ok,
	// Host data packet
	input  wire logic                pkt_start,
	input  wire logic                pkt_byte_valid,
	input  wire logic [7:0]          pkt_byte,
	input  wire logic                pkt_end,
	input  wire logic [4:0]          pkt_count,
	input  wire logic                pkt_ok,
	input  wire logic                pkt_crc_bad,
	input  wire logic                pkt_toggle,
	// Host handshake after our data
	input  wire logic                host_ack,
	input  wire logic                host_timeout,
	// Response to the packet layer
	output logic                     rsp_valid,
	output uemr_pkg::uemr_rsp_t      rsp_kind,
	output logic [3:0]               rsp_len,
	// Per-endpoint event pulses
	output logic [NUM_EP-1:0]        ep_irq
);
	import uemr_pkg::*;

	localparam int BIW = $clog2(EP_SIZE);

	logic [7:0]  mode_r [NUM_EP];
	logic [7:0]  cnt_r [NUM_EP];
	logic [7:0]  buf_r [EP_SIZE];
	logic [BIW:0] idx_r;
	logic        lock_r;
	uemr_state_t state_r;
	uemr_state_t state_nxt;
	logic [1:0]  ep_r;
	uemr_pid_t   pid_r;
	uemr_rsp_t   kind_r;
	uemr_rsp_t   kind_nxt;

	// Engine outputs of the combinational decision
	logic        eng_mode_we;
	logic [3:0]  eng_mode;
	logic        eng_cnt_we;
	logic [7:0]  eng_cnt;
	logic        eng_set_setup;
	logic        eng_set_in;
	logic        eng_set_out;
	logic        eng_set_ack;
	logic        eng_lock;
	logic        eng_irq;
	logic        eng_rsp_v;
	uemr_rsp_t   eng_rsp_k;
	logic [3:0]  eng_rsp_len;

	logic        tok_take;
	logic [7:0]  tok_mode;
	logic        tok_stall;
	logic [7:0]  cur_mode;
	logic        cur_stall;
	logic        pkt_valid;
	logic [3:0]  pkt_data_len;

	// R2 R7 R15 IN answer per mode
	function automatic uemr_rsp_t in_resp(input logic [3:0] m, input logic stl);
		unique case (m)
			`UEMR_MODE_NAK_INOUT, `UEMR_MODE_ACKOUT_NAKIN, `UEMR_MODE_NAK_IN,
			`UEMR_MODE_NAKIN_STOUT:                          in_resp = UEMR_RSP_NAK;
			`UEMR_MODE_STATUS_OUT, `UEMR_MODE_STALL_INOUT:   in_resp = UEMR_RSP_STALL;
			`UEMR_MODE_STATUS_IN, `UEMR_MODE_NAKOUT_STIN:    in_resp = UEMR_RSP_ZLP;
			`UEMR_MODE_RSV_7, `UEMR_MODE_ACKIN_STOUT:        in_resp = UEMR_RSP_DATA;
			`UEMR_MODE_ACK_IN: in_resp = stl ? UEMR_RSP_STALL : UEMR_RSP_DATA;
			`UEMR_MODE_DISABLE, `UEMR_MODE_IGN_INOUT, `UEMR_MODE_RSV_5,
			`UEMR_MODE_NAK_OUT, `UEMR_MODE_ACK_OUT:          in_resp = UEMR_RSP_NONE;
		endcase
	endfunction

	// R2 R15 OUT answer per mode
	function automatic uemr_rsp_t out_resp(input logic [3:0] m, input logic stl);
		unique case (m)
			`UEMR_MODE_NAK_INOUT, `UEMR_MODE_NAK_OUT,
			`UEMR_MODE_NAKOUT_STIN:                          out_resp = UEMR_RSP_NAK;
			`UEMR_MODE_STALL_INOUT, `UEMR_MODE_STATUS_IN:    out_resp = UEMR_RSP_STALL;
			`UEMR_MODE_STATUS_OUT, `UEMR_MODE_NAKIN_STOUT,
			`UEMR_MODE_ACKIN_STOUT:                          out_resp = UEMR_RSP_CHECK;
			`UEMR_MODE_ACKOUT_NAKIN:                         out_resp = UEMR_RSP_ACK;
			`UEMR_MODE_ACK_OUT: out_resp = stl ? UEMR_RSP_STALL : UEMR_RSP_ACK;
			`UEMR_MODE_DISABLE, `UEMR_MODE_IGN_INOUT, `UEMR_MODE_RSV_5,
			`UEMR_MODE_RSV_7, `UEMR_MODE_NAK_IN, `UEMR_MODE_ACK_IN: out_resp = UEMR_RSP_NONE;
		endcase
	endfunction

	function automatic logic setup_acc(input logic [3:0] m);
		unique case (m)
			`UEMR_MODE_DISABLE, `UEMR_MODE_RSV_5, `UEMR_MODE_RSV_7, `UEMR_MODE_NAK_OUT,
			`UEMR_MODE_ACK_OUT, `UEMR_MODE_NAK_IN, `UEMR_MODE_ACK_IN: setup_acc = 1'b0;
			default: setup_acc = 1'b1;
		endcase
	endfunction

	assign tok_take     = (state_r == UEMR_ST_IDLE) && tok_valid && tok_ok
	                      && (32'(tok_ep) < NUM_EP);
	assign tok_mode     = mode_r[tok_ep];
	// R1 stall bit exists only on non-control endpoints
	assign tok_stall    = (tok_ep != 2'h0) && tok_mode[`UEMR_MODE_STALL_BIT];
	assign cur_mode     = mode_r[ep_r];
	assign cur_stall    = (ep_r != 2'h0) && cur_mode[`UEMR_MODE_STALL_BIT];
	// R14 checks passed and count within endpoint size plus CRC
	assign pkt_valid    = pkt_ok && (pkt_count <= 5'(EP_SIZE) + `UEMR_CRC_BYTES);
	assign pkt_data_len = 4'(pkt_count - `UEMR_CRC_BYTES);

	// Transaction decision
	always_comb begin
		state_nxt     = state_r;
		kind_nxt      = kind_r;
		eng_mode_we   = 1'b0;
		eng_mode      = cur_mode[3:0];
		eng_cnt_we    = 1'b0;
		eng_cnt       = cnt_r[ep_r];
		eng_set_setup = 1'b0;
		eng_set_in    = 1'b0;
		eng_set_out   = 1'b0;
		eng_set_ack   = 1'b0;
		eng_lock      = 1'b0;
		eng_irq       = 1'b0;
		eng_rsp_v     = 1'b0;
		eng_rsp_k     = UEMR_RSP_NONE;
		eng_rsp_len   = 4'h0;
		unique case (state_r)
			UEMR_ST_IDLE: begin
				if (tok_take) begin
					unique case (tok_pid)
						UEMR_PID_IN: begin
							kind_nxt = in_resp(tok_mode[3:0], tok_stall);
							// R5 R6 data answer waits for the host handshake
							if (kind_nxt == UEMR_RSP_DATA || kind_nxt == UEMR_RSP_ZLP) begin
								eng_rsp_v = 1'b1;
								eng_rsp_k = UEMR_RSP_DATA;
								if (kind_nxt == UEMR_RSP_DATA)
									eng_rsp_len = cnt_r[tok_ep][3:0];
								state_nxt = UEMR_ST_HACK;
							// R3 R16 R25 NAK or STALL ends the transaction here
							end else if (kind_nxt != UEMR_RSP_NONE) begin
								eng_rsp_v  = 1'b1;
								eng_rsp_k  = kind_nxt;
								eng_set_in = 1'b1;
								eng_irq    = 1'b1;
							end
						end
						UEMR_PID_OUT: begin
							kind_nxt = out_resp(tok_mode[3:0], tok_stall);
							if (kind_nxt != UEMR_RSP_NONE)
								state_nxt = UEMR_ST_DATA;
						end
						UEMR_PID_SETUP: begin
							kind_nxt = UEMR_RSP_ACK;
							if (setup_acc(tok_mode[3:0]))
								state_nxt = UEMR_ST_DATA;
						end
						default: ;
					endcase
				end
			end
			UEMR_ST_DATA: begin
				// R17 SETUP flag at start of data
				if (pkt_start && pid_r == UEMR_PID_SETUP)
					eng_set_setup = 1'b1;
				if (tok_valid) begin
					state_nxt = UEMR_ST_IDLE;
				end else if (pkt_end) begin
					state_nxt = UEMR_ST_IDLE;
					if (pid_r == UEMR_PID_SETUP) begin
						// R26 bad SETUP: no answer, data marked invalid
						eng_cnt_we = 1'b1;
						eng_cnt    = {pkt_toggle, pkt_valid, 2'h0, pkt_data_len};
						eng_irq    = 1'b1;
						// R8 R21 valid SETUP: ACK, lock, mode to NAK-all
						if (pkt_valid) begin
							eng_rsp_v   = 1'b1;
							eng_rsp_k   = UEMR_RSP_ACK;
							eng_mode_we = 1'b1;
							eng_mode    = `UEMR_MODE_NAK_INOUT;
							eng_set_ack = 1'b1;
							eng_lock    = 1'b1;
						end
					// R12 invalid OUT stays silent
					end else if (pkt_valid) begin
						eng_set_out = 1'b1;
						eng_irq     = 1'b1;
						eng_rsp_v   = 1'b1;
						eng_rsp_k   = kind_r;
						if (kind_r == UEMR_RSP_ACK || kind_r == UEMR_RSP_CHECK) begin
							eng_cnt_we = 1'b1;
							eng_cnt    = {pkt_toggle, 1'b1, 2'h0, pkt_data_len};
						end
						// R4 zero length with toggle 1, else STALL
						if (kind_r == UEMR_RSP_CHECK) begin
							if (pkt_count == `UEMR_CRC_BYTES && pkt_toggle) begin
								eng_rsp_k = UEMR_RSP_ACK;
							end else begin
								eng_rsp_k   = UEMR_RSP_STALL;
								eng_mode_we = 1'b1;
								eng_mode    = `UEMR_MODE_STALL_INOUT;
							end
						end
						if (eng_rsp_k == UEMR_RSP_ACK) begin
							eng_set_ack = 1'b1;
							eng_lock    = 1'b1;
							eng_mode_we = 1'b1;
							unique case (cur_mode[3:0])
								// R22 ACK OUT falls back to NAK OUT
								`UEMR_MODE_ACK_OUT:      eng_mode = `UEMR_MODE_NAK_OUT;
								// R24 control write data goes to NAK-all
								`UEMR_MODE_ACKOUT_NAKIN: eng_mode = `UEMR_MODE_NAK_INOUT;
								// R9 status OUT accepted
								`UEMR_MODE_ACKIN_STOUT:  eng_mode = `UEMR_MODE_NAKIN_STOUT;
								default:                 eng_mode = cur_mode[3:0];
							endcase
						end
					end else if (kind_r == UEMR_RSP_ACK || kind_r == UEMR_RSP_CHECK) begin
						// R13 buffer was written, bad CRC corrupts it
						eng_cnt_we = 1'b1;
						eng_cnt    = {cnt_r[ep_r][7], 1'b0, cnt_r[ep_r][5:0]};
						eng_irq    = pkt_crc_bad;
					end
				end
			end
			UEMR_ST_HACK: begin
				if (host_ack) begin
					state_nxt   = UEMR_ST_IDLE;
					eng_set_in  = 1'b1;
					eng_set_ack = 1'b1;
					eng_lock    = 1'b1;
					// R13 completed transaction interrupts
					eng_irq     = 1'b1;
					eng_mode_we = 1'b1;
					unique case (cur_mode[3:0])
						// R23 ACK IN falls back to NAK IN
						`UEMR_MODE_ACK_IN:      eng_mode = `UEMR_MODE_NAK_IN;
						`UEMR_MODE_ACKIN_STOUT: eng_mode = `UEMR_MODE_NAKIN_STOUT;
						default:                eng_mode = cur_mode[3:0];
					endcase
				end else if (host_timeout || tok_valid) begin
					state_nxt = UEMR_ST_IDLE;
				end
			end
			default: state_nxt = UEMR_ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= UEMR_ST_IDLE;
			ep_r    <= 2'h0;
			pid_r   <= UEMR_PID_OUT;
			kind_r  <= UEMR_RSP_NONE;
		end else begin
			state_r <= state_nxt;
			kind_r  <= kind_nxt;
			if (tok_take) begin
				ep_r  <= tok_ep;
				pid_r <= tok_pid;
			end
		end
	end

	// Response and event outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsp_valid <= 1'b0;
			rsp_kind  <= UEMR_RSP_NONE;
			rsp_len   <= 4'h0;
			ep_irq    <= '0;
		end else begin
			rsp_valid <= eng_rsp_v;
			rsp_kind  <= eng_rsp_k;
			rsp_len   <= eng_rsp_len;
			ep_irq    <= '0;
			if (eng_irq)
				ep_irq[tok_take ? tok_ep : ep_r] <= 1'b1;
		end
	end

	// Control endpoint receive buffer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idx_r <= '0;
			for (int i = 0; i < EP_SIZE; i++)
				buf_r[i] <= 8'h00;
		end else if (state_r == UEMR_ST_DATA) begin
			if (pkt_start)
				idx_r <= '0;
			else if (pkt_byte_valid && ep_r == 2'h0 && 32'(idx_r) < EP_SIZE) begin
				buf_r[idx_r[BIW-1:0]] <= pkt_byte;
				idx_r <= idx_r + 1'b1;
			end
		end
	end

	// AXI4-Lite slave
	logic        aw_full_r;
	logic        w_full_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic        wstrb0_r;
	logic        wr_go;
	logic        aw_full_nxt;
	logic        w_full_nxt;
	logic        wr_map;
	logic        rd_map;
	logic [2:0]  wr_idx;
	logic [2:0]  rd_idx;
	logic        cpu_rd_ctl;
	logic [31:0] rd_word;

	assign wr_go       = aw_full_r && w_full_r && !s_axi_bvalid;
	assign aw_full_nxt = !wr_go && (aw_full_r || (s_axi_awvalid && s_axi_awready));
	assign w_full_nxt  = !wr_go && (w_full_r || (s_axi_wvalid && s_axi_wready));
	assign wr_idx      = awaddr_r[4:2];
	assign rd_idx      = s_axi_araddr[4:2];
	assign wr_map      = (awaddr_r[7:5] == 3'h0) && (32'(wr_idx) < 2 * NUM_EP);
	assign rd_map      = (s_axi_araddr[7:5] == 3'h0);
	assign cpu_rd_ctl  = s_axi_arvalid && s_axi_arready && rd_map
	                     && (s_axi_araddr[4:3] == 2'h0);

	always_comb begin
		rd_word = 32'h0000_0000;
		if (s_axi_araddr == `UEMR_OFS_BUF_LO)
			rd_word = {buf_r[3], buf_r[2], buf_r[1], buf_r[0]};
		else if (s_axi_araddr == `UEMR_OFS_BUF_HI)
			rd_word = {buf_r[7], buf_r[6], buf_r[5], buf_r[4]};
		else if (32'(rd_idx) < 2 * NUM_EP)
			rd_word = {24'h00_0000, rd_idx[0] ? cnt_r[rd_idx[2:1]] : mode_r[rd_idx[2:1]]};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r     <= 1'b0;
			w_full_r      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			awaddr_r      <= 8'h00;
			wdata_r       <= 32'h0000_0000;
			wstrb0_r      <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `UEMR_RESP_OKAY;
		end else begin
			aw_full_r     <= aw_full_nxt;
			w_full_r      <= w_full_nxt;
			s_axi_awready <= !aw_full_nxt;
			s_axi_wready  <= !w_full_nxt;
			if (s_axi_awvalid && s_axi_awready)
				awaddr_r <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r  <= s_axi_wdata;
				wstrb0_r <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `UEMR_RESP_OKAY : `UEMR_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `UEMR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_map ? rd_word : 32'h0000_0000;
			s_axi_rresp   <= rd_map ? `UEMR_RESP_OKAY : `UEMR_RESP_SLVERR;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// R18 lock set by engine wins over an unlocking read
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lock_r <= 1'b0;
		else if (eng_lock && ep_r == 2'h0)
			lock_r <= 1'b1;
		else if (cpu_rd_ctl)
			lock_r <= 1'b0;
	end

	// Mode and count registers; engine updates override the CPU
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// R10 all endpoints start disabled
			for (int i = 0; i < NUM_EP; i++) begin
				mode_r[i] <= `UEMR_REG_RST;
				cnt_r[i]  <= `UEMR_REG_RST;
			end
		end else begin
			for (int i = 0; i < NUM_EP; i++) begin
				// R18 locked control registers drop CPU writes
				if (wr_go && wr_map && wstrb0_r && 32'(wr_idx[2:1]) == i
				    && !(i == 0 && lock_r)) begin
					if (wr_idx[0])
						cnt_r[i] <= wdata_r[7:0];
					else
						mode_r[i] <= wdata_r[7:0];
				end
				if (eng_mode_we && 32'(ep_r) == i)
					mode_r[i][3:0] <= eng_mode;
				if (eng_cnt_we && 32'(ep_r) == i)
					cnt_r[i] <= eng_cnt;
			end
			// R11 R16 control endpoint token flags, set wins over a write
			if (ep_r == 2'h0 || (tok_take && tok_ep == 2'h0)) begin
				if (eng_set_setup)
					mode_r[0][`UEMR_FLAG_SETUP_BIT] <= 1'b1;
				if (eng_set_in && (tok_take ? tok_ep : ep_r) == 2'h0)
					mode_r[0][`UEMR_FLAG_IN_BIT] <= 1'b1;
				if (eng_set_out)
					mode_r[0][`UEMR_FLAG_OUT_BIT] <= 1'b1;
				if (eng_set_ack)
					mode_r[0][`UEMR_FLAG_ACK_BIT] <= 1'b1;
			end
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_disabled_silent: assert property (tok_take && tok_mode[3:0] == `UEMR_MODE_DISABLE |=> !rsp_valid ##1 !rsp_valid) else $error("disabled endpoint answered"); // R10
	a_nak_all_in: assert property (tok_take && tok_pid == UEMR_PID_IN && tok_mode[3:0] == `UEMR_MODE_NAK_INOUT |=> rsp_valid && rsp_kind == UEMR_RSP_NAK) else $error("IN in NAK-all not NAKed"); // R3
	a_stall_in: assert property (tok_take && tok_pid == UEMR_PID_IN && tok_stall && tok_mode[3:0] == `UEMR_MODE_ACK_IN |=> rsp_kind == UEMR_RSP_STALL) else $error("stall bit ignored"); // R1
	a_tx_count: assert property (tok_take && tok_pid == UEMR_PID_IN && tok_mode[3:0] == `UEMR_MODE_ACKIN_STOUT |=> rsp_kind == UEMR_RSP_DATA && rsp_len == $past(cnt_r[tok_ep][3:0])) else $error("wrong TX count"); // R5
	a_zlp_len: assert property (tok_take && tok_pid == UEMR_PID_IN && tok_mode[3:0] == `UEMR_MODE_STATUS_IN |=> rsp_valid && rsp_len == 4'h0) else $error("status IN not zero length"); // R6
	a_out_ignored: assert property (tok_take && tok_pid == UEMR_PID_OUT && tok_mode[3:0] == `UEMR_MODE_NAK_IN |=> state_r == UEMR_ST_IDLE && !rsp_valid) else $error("IN endpoint took OUT"); // R15
	a_bad_silent: assert property (state_r == UEMR_ST_DATA && !tok_valid && pkt_end && !pkt_ok |=> !rsp_valid) else $error("invalid packet answered"); // R12
	a_setup_nak: assert property (state_r == UEMR_ST_DATA && pid_r == UEMR_PID_SETUP && !tok_valid && pkt_end && pkt_valid |=> rsp_kind == UEMR_RSP_ACK && mode_r[$past(ep_r)][3:0] == `UEMR_MODE_NAK_INOUT) else $error("SETUP did not force NAK-all"); // R8
	a_check_ack: assert property (state_r == UEMR_ST_DATA && pid_r == UEMR_PID_OUT && kind_r == UEMR_RSP_CHECK && !tok_valid && pkt_end && pkt_ok && pkt_count == `UEMR_CRC_BYTES && pkt_toggle |=> rsp_kind == UEMR_RSP_ACK) else $error("status OUT not ACKed"); // R4
	a_ack_in_nak: assert property (state_r == UEMR_ST_HACK && host_ack && cur_mode[3:0] == `UEMR_MODE_ACK_IN |=> mode_r[$past(ep_r)][3:0] == `UEMR_MODE_NAK_IN) else $error("ACK IN mode not changed"); // R23
	a_lock_holds: assert property (lock_r && wr_go && wr_idx == 3'h0 && state_r == UEMR_ST_IDLE && !tok_valid |=> mode_r[0] == $past(mode_r[0])) else $error("locked register written"); // R18
	a_setup_flag: assert property (state_r == UEMR_ST_DATA && pkt_start && pid_r == UEMR_PID_SETUP && ep_r == 2'h0 |=> mode_r[0][`UEMR_FLAG_SETUP_BIT]) else $error("SETUP flag not set"); // R17

endmodule

// >>> sim/uemr_host_model.sv
// Host controller model: tokens, data packets and handshakes.
// Assumes one call at a time from the bench, issued after reset.
module uemr_host_model (
	// Clock
	input  wire logic		aclk,
	// Token
	output logic			tok_valid,
	output uemr_pkg::uemr_pid_t	tok_pid,
	output logic [1:0]		tok_ep,
	output logic			tok_ok,
	// Data packet
	output logic			pkt_start,
	output logic			pkt_byte_valid,
	output logic [7:0]		pkt_byte,
	output logic			pkt_end,
	output logic [4:0]		pkt_count,
	output logic			pkt_ok,
	output logic			pkt_crc_bad,
	output logic			pkt_toggle,
	// Handshake after device data
	output logic			host_ack,
	output logic			host_timeout
);
	timeunit 1ns;
	timeprecision 100ps;
	import uemr_pkg::*;
	initial begin
		{tok_valid, pkt_start, pkt_byte_valid, pkt_end, host_ack, host_timeout} = '0;
		{tok_ep, pkt_count, pkt_ok, pkt_crc_bad, pkt_toggle, pkt_byte} = '0;
		tok_pid = UEMR_PID_OUT;
		tok_ok = 1'b1;
	end
	// Count includes the two CRC bytes, so cnt-2 payload bytes go out
	task automatic send(input uemr_pid_t p, input logic [1:0] e, input logic [4:0] c,
		input logic t, input logic o);
		int i;
		@(posedge aclk);
		tok_valid <= 1'b1;
		tok_pid <= p;
		tok_ep <= e;
		@(posedge aclk);
		tok_valid <= 1'b0;
		if (p != UEMR_PID_IN) begin
			pkt_start <= 1'b1;
			@(posedge aclk);
			pkt_start <= 1'b0;
			for (i = 2; i < c; i++) begin
				pkt_byte_valid <= 1'b1;
				pkt_byte <= 8'($urandom);
				@(posedge aclk);
			end
			// Released byte lane shows no stale value
			pkt_byte_valid <= 1'b0;
			pkt_byte <= ~pkt_byte;
			{pkt_end, pkt_count, pkt_ok, pkt_crc_bad, pkt_toggle} <= {1'b1, c, o, ~o, t};
			@(posedge aclk);
			pkt_end <= 1'b0;
		end
		repeat (4) @(posedge aclk);
	endtask
	task automatic ack();
		@(posedge aclk);
		host_ack <= 1'b1;
		@(posedge aclk);
		host_ack <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask
endmodule

// >>> sim/uemr_responder_test.sv
// Self-checking bench of the endpoint mode responder.
// Assumes the design files and the host model are compiled first.
module uemr_responder_test;
	timeunit 1ns;
	timeprecision 100ps;
	import uemr_pkg::*;
	logic		aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic		s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic		s_axi_rready, tok_valid, tok_ok, pkt_start, pkt_byte_valid, pkt_end;
	logic		pkt_ok, pkt_crc_bad, pkt_toggle, host_ack, host_timeout, rsp_valid;
	logic [7:0]	s_axi_awaddr, s_axi_araddr, pkt_byte, rd, c;
	logic [31:0]	s_axi_wdata, s_axi_rdata;
	logic [3:0]	s_axi_wstrb, rsp_len, rl;
	logic [1:0]	s_axi_bresp, s_axi_rresp, tok_ep, rr;
	logic [4:0]	pkt_count;
	logic [2:0]	ep_irq;
	uemr_pid_t	tok_pid;
	uemr_rsp_t	rsp_kind, rk;
	int		bad_count, comparisons, rn, rn0, k, ni, ni0;
	uemr_responder dut (.*);
	uemr_host_model host (.*);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (ep_irq !== 3'h0) ni <= ni + 1;
		if (rsp_valid === 1'b1) begin
			rk <= rsp_kind;
			rl <= rsp_len;
			rn <= rn + 1;
		end
	end
	function automatic logic [7:0] after_ack(input logic [7:0] m);
		case (m)
			8'h09: return 8'h08;
			8'h0B: return 8'h01;
			8'h0D: return 8'h0C;
			8'h0F: return 8'h0E;
			default: return m;
		endcase
	endfunction
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t register %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_rsp(input uemr_rsp_t e, input logic [3:0] l);
		comparisons++;
		if ((rn - rn0) != int'(e != UEMR_RSP_NONE) || (e != UEMR_RSP_NONE && rk !== e)
			|| (e == UEMR_RSP_DATA && rl !== l)
			|| (ni - ni0) != int'(e != UEMR_RSP_NONE && e != UEMR_RSP_DATA)) begin
			bad_count++;
			$display("CHECK FAILED %0t response %0d expected %0d", $time, rk, e);
		end
	endtask
	task automatic tx(input uemr_pid_t p, input logic [1:0] e, input logic [4:0] n,
		input logic t, input logic o, input uemr_rsp_t x, input logic [3:0] l);
		rn0 = rn;
		ni0 = ni;
		host.send(p, e, n, t, o);
		cmp_rsp(x, l);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		{rd, rr} = {s_axi_rdata[7:0], s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#300us;
		bad_count++;
		test_done();
	end
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
		void'($urandom(32'hc457));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rdr(8'h08);
		cmp(rd, 8'h00);
		rdr(8'h24);
		cmp({6'h0, rr}, 8'h02);
		tx(UEMR_PID_OUT, 2'd2, 5'd4, 1'b0, 1'b1, UEMR_RSP_NONE, 4'h0);
		$display("test reset and disabled done");
		wr(8'h00, 8'h01);
		cmp({6'h0, rr}, 8'h00);
		tx(UEMR_PID_IN, 2'd0, 5'd0, 1'b0, 1'b1, UEMR_RSP_NAK, 4'h0);
		tx(UEMR_PID_OUT, 2'd0, 5'd4, 1'b1, 1'b1, UEMR_RSP_NAK, 4'h0);
		tx(UEMR_PID_SETUP, 2'd0, 5'd10, 1'b0, 1'b1, UEMR_RSP_ACK, 4'h0);
		wr(8'h00, 8'h0F);
		rdr(8'h00);
		cmp(rd, 8'hF1);
		rdr(8'h04);
		cmp(rd, 8'h48);
		wr(8'h00, 8'h0F);
		rdr(8'h00);
		cmp({4'h0, rd[3:0]}, 8'h0F);
		tx(UEMR_PID_IN, 2'd0, 5'd0, 1'b0, 1'b1, UEMR_RSP_DATA, 4'h8);
		host.ack();
		rdr(8'h00);
		cmp({4'h0, rd[3:0]}, after_ack(8'h0F));
		wr(8'h00, 8'h0F);
		tx(UEMR_PID_OUT, 2'd0, 5'd2, 1'b1, 1'b1, UEMR_RSP_ACK, 4'h0);
		rdr(8'h00);
		cmp({4'h0, rd[3:0]}, 8'h0E);
		wr(8'h00, 8'h0F);
		tx(UEMR_PID_OUT, 2'd0, 5'd2, 1'b0, 1'b1, UEMR_RSP_STALL, 4'h0);
		wr(8'h00, 8'h0B);
		tx(UEMR_PID_OUT, 2'd0, 5'd4, 1'b1, 1'b1, UEMR_RSP_ACK, 4'h0);
		rdr(8'h00);
		cmp({4'h0, rd[3:0]}, after_ack(8'h0B));
		wr(8'h00, 8'h06);
		wr(8'h18, 8'h00);
		cmp({6'h0, rr}, 8'h02);
		tx(UEMR_PID_IN, 2'd0, 5'd0, 1'b0, 1'b1, UEMR_RSP_DATA, 4'h0);
		host.ack();
		$display("test control endpoint done");
		wr(8'h08, 8'h09);
		c = 8'(2 + $urandom % 9);
		tx(UEMR_PID_OUT, 2'd1, c[4:0], 1'b0, 1'b1, UEMR_RSP_ACK, 4'h0);
		rdr(8'h08);
		cmp({4'h0, rd[3:0]}, after_ack(8'h09));
		tx(UEMR_PID_IN, 2'd1, 5'd0, 1'b0, 1'b1, UEMR_RSP_NONE, 4'h0);
		tx(UEMR_PID_OUT, 2'd1, 5'd4, 1'b0, 1'b0, UEMR_RSP_NONE, 4'h0);
		tx(UEMR_PID_OUT, 2'd1, 5'd13, 1'b0, 1'b1, UEMR_RSP_NONE, 4'h0);
		tx(UEMR_PID_OUT, 2'd1, 5'd4, 1'b0, 1'b1, UEMR_RSP_NAK, 4'h0);
		for (k = 0; k < 4; k++) begin
			c = 8'($urandom % 9);
			wr(8'h0C, c);
			wr(8'h08, k == 0 ? 8'h8D : 8'h0D);
			tx(UEMR_PID_IN, 2'd1, 5'd0, 1'b0, 1'b1, k == 0 ? UEMR_RSP_STALL : UEMR_RSP_DATA,
				c[3:0]);
			if (k != 0) host.ack();
			rdr(8'h08);
			cmp({4'h0, rd[3:0]}, k == 0 ? 8'h0D : after_ack(8'h0D));
			if (k != 0) tx(UEMR_PID_OUT, 2'd1, 5'd4, 1'b0, 1'b1, UEMR_RSP_NONE, 4'h0);
		end
		$display("test data endpoint done");
		test_done();
	end
endmodule
